// ---- include/nsd_pkg.sv ----
// Purpose: Shared constants and types for the slave cycle decoder
// Assumes: 50 MHz core clock, expansion bus beat of 100 ns
// Notes:   Bus lines are active low; decode works on the inverted levels, except the top byte slot match on raw levels
package nsd_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CORE_PERIOD_NS   = 20;
  localparam int BUS_PERIOD_NS    = 100;
  localparam int BEAT_CYCLES      = BUS_PERIOD_NS / CORE_PERIOD_NS;
  localparam int BUS_TIMEOUT_NS   = 25600;
  localparam int TIMEOUT_BEATS    = BUS_TIMEOUT_NS / BUS_PERIOD_NS;
  // Forced answer well inside the bus timeout
  localparam int GUARD_BEATS      = TIMEOUT_BEATS - 56;
  localparam int DIV_W            = 3;
  localparam int GUARD_W          = 8;

  // ****************************************************
  // Address fields
  // ****************************************************
  localparam int SUPER_MSB        = 31;
  localparam int SUPER_LSB        = 28;
  localparam int SLOT_MSB         = 27;
  localparam int SLOT_LSB         = 24;
  localparam int TGT_MSB          = 19;
  localparam int TGT_LSB          = 18;
  localparam int LOC_MSB          = 15;
  localparam int LOC_LSB          = 2;
  localparam int LOC_W            = LOC_MSB - LOC_LSB + 1;
  // Top super slot on the raw (active low) lines
  localparam logic [3:0] TOP_SUPER_RAW = 4'h0;

  // Target select codes on logical AD19..18
  localparam logic [1:0] TGT_NONE = 2'h0;
  localparam logic [1:0] TGT_RAM  = 2'h1;
  localparam logic [1:0] TGT_NETC = 2'h2;
  localparam logic [1:0] TGT_ROM  = 2'h3;

  // Status codes on raw lines, bit 0 is TM0
  localparam logic [1:0] ST_DONE_RAW = 2'h0;
  localparam logic [1:0] ST_ERR_RAW  = 2'h1;

  typedef enum logic [2:0] {
    NSD_IDLE = 3'b001,
    NSD_BUSY = 3'b010,
    NSD_ACK  = 3'b100
  } nsd_state_t;

endpackage : nsd_pkg

// ---- include/nsd_dec_if.sv ----
// Purpose: Carries decode results from the decoder to the cycle control
// Assumes: Combinational, valid in the same core cycle as its inputs
// Notes:   None
`timescale 1ns/1ps
interface nsd_dec_if;
  import nsd_pkg::*;
  logic             hit;
  logic             ram;
  logic             rom;
  logic             netc;
  logic             wr;
  logic [1:0]       be;
  logic             err;
  logic [LOC_W-1:0] loc;

  modport dec (output hit, ram, rom, netc, wr, be, err, loc);
  modport use_side (input hit, ram, rom, netc, wr, be, err, loc);
endinterface : nsd_dec_if

// ---- rtl/nsd_addr_decode.sv ----
// Purpose: Slot, target, direction and lane decode of a start beat
// Assumes: Raw active-low bus levels at the inputs
// Notes:   Purely combinational
`timescale 1ns/1ps
module nsd_addr_decode
  import nsd_pkg::*;
(
  input  wire logic [31:0] ad_n,
  input  wire logic [1:0]  tm_n,
  input  wire logic [3:0]  slot_id_n,
  nsd_dec_if.dec           d
);
  logic [31:0] ad;
  logic [1:0]  tm;
  logic [1:0]  tgt;

  always_comb begin
    // Low bytes go through inverting latches
    ad     = ~ad_n;
    tm     = ~tm_n;
    tgt    = ad[TGT_MSB:TGT_LSB];
    // Top byte compared uninverted with the slot id lines; 23..20 unused
    d.hit  = (ad_n[SUPER_MSB:SUPER_LSB] == TOP_SUPER_RAW) &&
             (ad_n[SLOT_MSB:SLOT_LSB] == slot_id_n);
    d.ram  = (tgt == TGT_RAM);
    d.rom  = (tgt == TGT_ROM);
    d.netc = (tgt == TGT_NETC);
    d.loc  = ad[LOC_MSB:LOC_LSB];
    // Controller uses TM0 for direction, memories TM1
    d.wr   = d.netc ? tm[0] : tm[1];
    d.be   = 2'h0;
    if (d.ram && tm[1] && !ad[1]) begin
      if (!tm[0]) begin
        d.be = 2'h3;
      end else begin
        d.be = ad[0] ? 2'h2 : 2'h1;
      end
    end
    d.err  = (tgt == TGT_NONE) || (d.rom && tm[1]);
  end
endmodule : nsd_addr_decode

// ---- rtl/nsd_beat_timer.sv ----
// Purpose: Bus beat enable divider and wait guard counter
// Assumes: One core clock; beat enable is a one-cycle pulse
// Notes:   Guard forces an answer long before the bus timeout
`timescale 1ns/1ps
module nsd_beat_timer
  import nsd_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic wait_run,
  output logic      beat_ce,
  output logic      guard_hit
);
  logic [DIV_W-1:0]   div_q;
  logic [DIV_W-1:0]   div_d;
  logic [GUARD_W-1:0] wait_q;
  logic [GUARD_W-1:0] wait_d;

  always_comb begin
    beat_ce   = (div_q == DIV_W'(BEAT_CYCLES - 1));
    div_d     = beat_ce ? '0 : div_q + 1'b1;
    guard_hit = (wait_q >= GUARD_W'(GUARD_BEATS));
    wait_d    = wait_q;
    if (!wait_run) begin
      wait_d = '0;
    end else if (beat_ce && !guard_hit) begin
      wait_d = wait_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q  <= '0;
      wait_q <= '0;
    end else begin
      div_q  <= div_d;
      wait_q <= wait_d;
    end
  end

  AST_GUARD_BOUND: assert property (@(posedge core_clk) disable iff (rst)
    wait_q <= GUARD_W'(GUARD_BEATS)) else $error("Wait guard overran");
endmodule : nsd_beat_timer

// ---- rtl/nsd_slave_cycle_decode.sv ----
// Purpose: Slave cycle decode and acknowledge for an expansion bus card
// Assumes: Bus pins synchronous to core_clk; beat enable every 100 ns
// Notes:   Slave only; one word per cycle; no parity, no arbitration
`timescale 1ns/1ps

// ****************************************************
// Slave cycle control
// ****************************************************
// Summary of operation
// - Decode address and mode on start beat
// - Respond only to own geographic slot
// - Top super slot plus slot field match
// - AD19..18 pick RAM, ROM or controller
// - AD15..2 form the target word location
// - AD23..20 not decoded, AD1..0 only for RAM lanes
// - 24-bit and 32-bit addresses behave alike
// - Slot space split into four blocks
// - Direction from TM1 or TM0 by target
// - RAM write lanes from TM0 and AD1..0
// - No device addressed gives bus error
// - ROM write errors, rest complete
// - Acknowledge one beat with status driven
// - Complete is 11, error is TM0 low
// - Never timeout or retry, always answer
// - Slave only, no parity, no arbitration
// - Single word transfers only
// - Start first beat, ack in last
// - Drive and sample on 100 ns beats
// - Top byte compared uninverted with id
module nsd_slave_cycle_decode
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             start_n,
  input  wire logic [31:0]      ad_n,
  input  wire logic [1:0]       tm_n_i,
  output logic      [1:0]       tm_n_o,
  output logic                  tm_n_oe,
  output logic                  ack_n_o,
  output logic                  ack_n_oe,
  input  wire logic [3:0]       slot_id_n,
  input  wire logic             tgt_ready,
  output logic                  ram_sel,
  output logic                  rom_sel,
  output logic                  netc_sel,
  output logic                  tgt_wr,
  output logic      [1:0]       ram_be,
  output logic      [nsd_pkg::LOC_W-1:0] tgt_loc
);
  import nsd_pkg::*;

  // ****************************************************
  // Decode and beat timing
  // ****************************************************
  nsd_dec_if dec_if ();

  logic beat_ce;
  logic guard_hit;
  logic wait_run;

  nsd_addr_decode u_dec (
    .ad_n      (ad_n),
    .tm_n      (tm_n_i),
    .slot_id_n (slot_id_n),
    .d         (dec_if.dec)
  );

  nsd_beat_timer u_tmr (
    .core_clk  (core_clk),
    .rst       (rst),
    .wait_run  (wait_run),
    .beat_ce   (beat_ce),
    .guard_hit (guard_hit)
  );

  // ****************************************************
  // Cycle state
  // ****************************************************
  nsd_state_t       st_q;
  nsd_state_t       st_d;
  logic             ram_q;
  logic             ram_d;
  logic             rom_q;
  logic             rom_d;
  logic             netc_q;
  logic             netc_d;
  logic             wr_q;
  logic             wr_d;
  logic [1:0]       be_q;
  logic [1:0]       be_d;
  logic             err_q;
  logic             err_d;
  logic [LOC_W-1:0] loc_q;
  logic [LOC_W-1:0] loc_d;
  logic [1:0]       stat_q;
  logic [1:0]       stat_d;
  logic             take;

  // Start is only looked at on a beat edge, as the bus samples it
  assign take     = beat_ce && !start_n && dec_if.hit;
  assign wait_run = (st_q == NSD_BUSY);

  always_comb begin
    st_d   = st_q;
    ram_d  = ram_q;
    rom_d  = rom_q;
    netc_d = netc_q;
    wr_d   = wr_q;
    be_d   = be_q;
    err_d  = err_q;
    loc_d  = loc_q;
    stat_d = stat_q;
    unique case (st_q)
      NSD_IDLE: begin
        if (take) begin
          st_d   = NSD_BUSY;
          // Errors never reach a target, so no strobe is raised
          ram_d  = dec_if.ram && !dec_if.err;
          rom_d  = dec_if.rom && !dec_if.err;
          netc_d = dec_if.netc;
          wr_d   = dec_if.wr;
          be_d   = dec_if.be;
          err_d  = dec_if.err;
          loc_d  = dec_if.loc;
        end
      end
      NSD_BUSY: begin
        // Zero or more wait beats, bounded by the guard
        if (beat_ce && (err_q || tgt_ready || guard_hit)) begin
          st_d   = NSD_ACK;
          stat_d = err_q ? ST_ERR_RAW : ST_DONE_RAW;
        end
      end
      NSD_ACK: begin
        if (beat_ce) begin
          st_d   = NSD_IDLE;
          ram_d  = 1'b0;
          rom_d  = 1'b0;
          netc_d = 1'b0;
          wr_d   = 1'b0;
          be_d   = 2'h0;
          err_d  = 1'b0;
        end
      end
      default: begin
        st_d = NSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q   <= NSD_IDLE;
      ram_q  <= 1'b0;
      rom_q  <= 1'b0;
      netc_q <= 1'b0;
      wr_q   <= 1'b0;
      be_q   <= 2'h0;
      err_q  <= 1'b0;
      loc_q  <= '0;
      stat_q <= ST_DONE_RAW;
    end else begin
      st_q   <= st_d;
      ram_q  <= ram_d;
      rom_q  <= rom_d;
      netc_q <= netc_d;
      wr_q   <= wr_d;
      be_q   <= be_d;
      err_q  <= err_d;
      loc_q  <= loc_d;
      stat_q <= stat_d;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Only two of the four status codes can ever leave this block
  assign ack_n_oe = (st_q == NSD_ACK);
  assign ack_n_o  = 1'b0;
  assign tm_n_oe  = (st_q == NSD_ACK);
  assign tm_n_o   = stat_q;
  assign ram_sel  = ram_q;
  assign rom_sel  = rom_q;
  assign netc_sel = netc_q;
  assign tgt_wr   = wr_q;
  // Lanes only matter for RAM writes
  assign ram_be   = (ram_q && wr_q) ? be_q : 2'h0;
  assign tgt_loc  = loc_q;

  // ****************************************************
  // Checks
  // ****************************************************
  AST_ACK_ONE_BEAT: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ack_n_oe) |-> ack_n_oe [*5] ##1 !ack_n_oe)
    else $error("Acknowledge not exactly one beat");

  AST_STATUS_WITH_ACK: assert property (@(posedge core_clk) disable iff (rst)
    tm_n_oe == ack_n_oe) else $error("Status drive not aligned to acknowledge");

  AST_STATUS_LEGAL: assert property (@(posedge core_clk) disable iff (rst)
    tm_n_oe |-> (tm_n_o == ST_DONE_RAW || tm_n_o == ST_ERR_RAW))
    else $error("Illegal status code driven");

  AST_FOREIGN_IGNORED: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE && beat_ce && !dec_if.hit) |=>
      (st_q == NSD_IDLE && !ack_n_oe && !ram_sel && !rom_sel && !netc_sel))
    else $error("Foreign cycle was answered");

  AST_ROM_WRITE_ERR: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE && take && dec_if.rom && !tm_n_i[1]) |->
      ##[1:15] (ack_n_oe && tm_n_o == ST_ERR_RAW))
    else $error("ROM write not answered with error");

  AST_NODEV_ERR: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE && take && ad_n[TGT_MSB:TGT_LSB] == 2'h3) |->
      ##[1:15] (ack_n_oe && tm_n_o == ST_ERR_RAW))
    else $error("Empty target not answered with error");

  AST_RAM_READ_DONE: assert property (@(posedge core_clk) disable iff (rst)
    (ack_n_oe && ram_sel) |-> tm_n_o == ST_DONE_RAW)
    else $error("RAM cycle answered with error");

  AST_TAKE_DECODES: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE && take) |=>
      (st_q == NSD_BUSY && tgt_loc == ~$past(ad_n[LOC_MSB:LOC_LSB])))
    else $error("Start beat not decoded");

  AST_RAM_LANES: assert property (@(posedge core_clk) disable iff (rst)
    (ram_be != 2'h0) |-> (ram_sel && tgt_wr))
    else $error("RAM lanes enabled outside a RAM write");

  AST_RAM_BOTH_LANES: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE && take && dec_if.ram && tm_n_i == 2'h1 && ad_n[1]) |=>
      (ram_be == 2'h3))
    else $error("Word write did not enable both lanes");

  AST_RAM_ONE_LANE: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE && take && dec_if.ram && tm_n_i == 2'h0 && ad_n[1]) |=>
      (ram_be == ($past(ad_n[0]) ? 2'h1 : 2'h2)))
    else $error("Byte write enabled the wrong lane");

  AST_NETC_DONE: assert property (@(posedge core_clk) disable iff (rst)
    (ack_n_oe && netc_sel) |-> tm_n_o == ST_DONE_RAW)
    else $error("Controller cycle answered with error");

  AST_ROM_READ_DONE: assert property (@(posedge core_clk) disable iff (rst)
    (ack_n_oe && rom_sel) |-> tm_n_o == ST_DONE_RAW)
    else $error("ROM read answered with error");

  AST_ONE_TARGET: assert property (@(posedge core_clk) disable iff (rst)
    $onehot0({ram_sel, rom_sel, netc_sel}))
    else $error("More than one target strobe raised");

  AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE) |-> (!ack_n_oe && !tm_n_oe && !ram_sel && !rom_sel && !netc_sel))
    else $error("Outputs active while idle");

  AST_ACK_LEVEL: assert property (@(posedge core_clk) disable iff (rst)
    ack_n_oe |-> (ack_n_o == 1'b0))
    else $error("Acknowledge driven at the wrong level");

  AST_ACK_FROM_BUSY: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ack_n_oe) |-> ($past(st_q) == NSD_BUSY))
    else $error("Acknowledge raised without a taken cycle");

  AST_ERR_NO_STROBE: assert property (@(posedge core_clk) disable iff (rst)
    (st_q != NSD_IDLE && err_q) |-> !(ram_sel || rom_sel))
    else $error("Memory strobe raised on an error cycle");

  AST_WR_DIR_NETC: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE && take && dec_if.netc) |=> (tgt_wr == !$past(tm_n_i[0])))
    else $error("Controller direction not taken from TM0");

  AST_WR_DIR_MEM: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == NSD_IDLE && take && (dec_if.ram || dec_if.rom)) |=>
      (tgt_wr == !$past(tm_n_i[1])))
    else $error("Memory direction not taken from TM1");

  AST_STATUS_STABLE: assert property (@(posedge core_clk) disable iff (rst)
    (ack_n_oe && $past(ack_n_oe)) |-> $stable(tm_n_o))
    else $error("Status changed while acknowledge stands");

  AST_LOC_HELD: assert property (@(posedge core_clk) disable iff (rst)
    (st_q != NSD_IDLE && $past(st_q) != NSD_IDLE) |-> $stable(tgt_loc))
    else $error("Location changed during a cycle");

  AST_HIT_SLOT: assert property (@(posedge core_clk) disable iff (rst)
    take |-> (ad_n[SUPER_MSB:SUPER_LSB] == TOP_SUPER_RAW &&
      ad_n[SLOT_MSB:SLOT_LSB] == slot_id_n))
    else $error("Cycle taken for another slot");

  // ****************************************************
  // Answer time monitor
  // ****************************************************
  // Cycle count kept here so the bound needs no long repetition
  logic [10:0] busy_cnt_q;
  logic [10:0] busy_cnt_d;

  always_comb begin
    busy_cnt_d = busy_cnt_q;
    if (!wait_run) begin
      busy_cnt_d = '0;
    end else if (busy_cnt_q != '1) begin
      busy_cnt_d = busy_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end

  AST_BUSY_BOUNDED: assert property (@(posedge core_clk) disable iff (rst)
    busy_cnt_q < 11'(TIMEOUT_BEATS * BEAT_CYCLES))
    else $error("Cycle not answered inside the bus timeout");

endmodule : nsd_slave_cycle_decode

// ---- tb/nsd_host_model.sv ----
// Purpose: Bus master model issuing single word cycles to the card
// Assumes: Pulled-up active-low lines; requests change at falling edges
// Notes:   Data placed on AD after the start beat is random, never checked
`timescale 1ns/1ps
module nsd_host_model (
  input  wire logic        core_clk,
  input  wire logic        ack_n_oe,
  input  wire logic        tm_n_oe,
  input  wire logic [1:0]  tm_n_o,
  output logic             start_n,
  output logic      [31:0] ad_n,
  output logic      [1:0]  tm_n_w
);
  logic       tm_drv;
  logic [1:0] tm_val;

  // Released lines float to the pull-up level, never the last value
  assign tm_n_w = tm_n_oe ? tm_n_o : (tm_drv ? tm_val : 2'h3);

  initial begin
    start_n = 1'b1;
    ad_n    = '1;
    tm_drv  = 1'b0;
    tm_val  = 2'h3;
  end

  // ****************************************************
  // One transfer
  // ****************************************************
  task automatic bus_cycle(input logic [31:0] a_n, input logic [1:0] t_n, input int wmax,
                           output logic got, output logic [1:0] st, output int len);
    got = 1'b0;
    st  = 2'h3;
    len = 0;
    @(negedge core_clk);
    start_n = 1'b0;
    ad_n    = a_n;
    tm_drv  = 1'b1;
    tm_val  = t_n;
    // Five core cycles span exactly one bus beat, so one sampling point
    repeat (5) @(negedge core_clk);
    start_n = 1'b1;
    tm_drv  = 1'b0;
    ad_n    = $urandom;
    for (int n = 0; n < wmax && !got; n++) begin
      @(negedge core_clk);
      if (ack_n_oe === 1'b1) begin
        got = 1'b1;
        st  = tm_n_w;
      end
    end
    while (got && ack_n_oe === 1'b1 && len < 20) begin
      len++;
      @(negedge core_clk);
    end
    ad_n = '1;
  endtask : bus_cycle
endmodule : nsd_host_model

// ---- tb/tb_nsd_slave_cycle_decode.sv ----
// Purpose: Self-checking bench for the slave cycle decoder
// Assumes: 50 MHz core clock; inputs change at falling edges
// Notes:   Wait guard is a package constant, so the slow cycle runs full length
`timescale 1ns/1ps
module tb_nsd_slave_cycle_decode;
  import nsd_pkg::*;
  logic             core_clk, rst, start_n, tgt_ready, hold_rdy;
  logic [31:0]      ad_n;
  logic [1:0]       tm_n_w, tm_n_o, ram_be, cap_be;
  logic             tm_n_oe, ack_n_o, ack_n_oe, ram_sel, rom_sel, netc_sel, tgt_wr;
  logic             cap_wr, cap_ack, cap_toe;
  logic [2:0]       cap_sel;
  logic [3:0]       slot_id_n;
  logic [LOC_W-1:0] tgt_loc;
  int               fails, samples_checked;

  nsd_slave_cycle_decode dut_u (.core_clk(core_clk), .rst(rst), .start_n(start_n), .ad_n(ad_n),
    .tm_n_i(tm_n_w), .tm_n_o(tm_n_o), .tm_n_oe(tm_n_oe), .ack_n_o(ack_n_o), .ack_n_oe(ack_n_oe),
    .slot_id_n(slot_id_n), .tgt_ready(tgt_ready), .ram_sel(ram_sel), .rom_sel(rom_sel),
    .netc_sel(netc_sel), .tgt_wr(tgt_wr), .ram_be(ram_be), .tgt_loc(tgt_loc));
  nsd_host_model host_u (.core_clk(core_clk), .ack_n_oe(ack_n_oe), .tm_n_oe(tm_n_oe),
    .tm_n_o(tm_n_o), .start_n(start_n), .ad_n(ad_n), .tm_n_w(tm_n_w));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Target finishes at random; capture outputs while acknowledge stands
  always @(negedge core_clk) begin
    tgt_ready <= hold_rdy ? 1'b0 : 1'($urandom);
    if (ack_n_oe === 1'b1) begin
      cap_sel <= {ram_sel, rom_sel, netc_sel};
      cap_wr  <= tgt_wr;
      cap_be  <= ram_be;
      cap_ack <= ack_n_o;
      cap_toe <= tm_n_oe;
    end
  end

  // ****************************************************
  // Expectation and checking
  // ****************************************************
  // Result bits: hit, error, ram, rom, controller, write, lanes
  function automatic logic [7:0] expect_fn(logic [31:0] a_n, logic [1:0] t_n, logic [3:0] id_n);
    logic [31:0] a;
    logic [1:0]  t;
    logic [7:0]  r;
    a = ~a_n;
    t = ~t_n;
    r = 8'h00;
    if (a_n[31:28] == TOP_SUPER_RAW && a_n[27:24] == id_n) begin
      r[7] = 1'b1;
      case (a[19:18])
        TGT_RAM: begin
          r[5] = 1'b1;
          r[2] = t[1];
          if (t[1] && !a[1]) r[1:0] = t[0] ? (a[0] ? 2'h2 : 2'h1) : 2'h3;
        end
        TGT_ROM: begin
          r[2] = t[1];
          r[6] = t[1];
          r[4] = !t[1];
        end
        TGT_NETC: begin
          r[3] = 1'b1;
          r[2] = t[0];
        end
        default: r[6] = 1'b1;
      endcase
    end
    return r;
  endfunction : expect_fn

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic run_one(input logic [31:0] a_n, input logic [1:0] t_n, input int wmax);
    logic [7:0] e;
    logic       got;
    logic [1:0] st;
    int         len;
    e = expect_fn(a_n, t_n, slot_id_n);
    host_u.bus_cycle(a_n, t_n, e[7] ? wmax : 20, got, st, len);
    check("acknowledge seen", got, e[7]);
    if (e[7] && !got) begin
      finish_test();
    end
    if (got) begin
      check("status", st, e[6] ? ST_ERR_RAW : ST_DONE_RAW);
      check("ack length", len, 5);
      check("ack drive", {cap_toe, cap_ack}, 2'h2);
      check("selects", cap_sel, e[5:3]);
      if (!e[6]) check("direction", cap_wr, e[2]);
      check("lanes", cap_be, e[1:0]);
      if (e[5:3] != 3'h0) check("location", tgt_loc, {18'h0, ~a_n[15:2]});
    end else begin
      check("foreign selects", {ram_sel, rom_sel, netc_sel}, 3'h0);
    end
    repeat (10) @(negedge core_clk);
  endtask : run_one

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    logic [31:0] a;
    rst             = 1'b1;
    hold_rdy        = 1'b0;
    slot_id_n       = 4'h6;
    fails           = 0;
    samples_checked = 0;
    void'($urandom(11));
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    // Every target code, mode pair and low address pair
    for (int i = 0; i < 64; i++) begin
      a         = $urandom;
      a[31:24]  = {TOP_SUPER_RAW, slot_id_n};
      a[19:18]  = 2'(i >> 4);
      a[1:0]    = 2'(i >> 2);
      run_one(a, 2'(i), 200);
    end
    run_one({4'h0, slot_id_n ^ 4'h1, 24'hfbfff0}, 2'h3, 0);
    run_one({4'h1, slot_id_n, 24'hfbfff0}, 2'h3, 0);
    // Unused nibble AD23..20 must not change the decode
    for (int k = 0; k < 16; k++) begin
      run_one({4'h0, slot_id_n, 4'(k), 20'hbfff0}, 2'h1, 200);
    end
    // Target never ready: the guard must still answer in time
    hold_rdy = 1'b1;
    run_one({4'h0, slot_id_n, 24'hfbfff0}, 2'h3, 1100);
    hold_rdy = 1'b0;
    for (int r = 0; r < 150; r++) begin
      slot_id_n = 4'($urandom);
      a         = $urandom;
      if ($urandom_range(3) != 0) a[31:24] = {TOP_SUPER_RAW, slot_id_n};
      run_one(a, 2'($urandom), 200);
    end
    finish_test();
  end
endmodule : tb_nsd_slave_cycle_decode
